// file: core/spcb_pkg.sv
package spcb_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_IRQ_LEVEL_SENSE = 12'h64c;
  localparam logic [11:0] OFS_IRQ_PENDING     = 12'h650;
  localparam logic [11:0] OFS_IRQ_BLOCK       = 12'h654;
  localparam logic [11:0] OFS_LINK_CTRL_A     = 12'h844;
  localparam logic [11:0] OFS_LINK_CTRL_B     = 12'h848;
  localparam logic [11:0] OFS_LEGACY_DECODE   = 12'h84c;
  localparam logic [11:0] OFS_FWD_POLICY      = 12'h850;
  localparam logic [11:0] OFS_LINK_CTRL_C     = 12'h854;
  localparam logic [11:0] OFS_PHY_MAIN        = 12'h858;
  localparam logic [11:0] OFS_PHY_LANE        = 12'h85c;
  localparam logic [11:0] OFS_PHY_MARGIN      = 12'h860;
  localparam logic [11:0] OFS_LINK_CTRL_D     = 12'h864;
  localparam logic [11:0] OFS_LINK_CTRL_E     = 12'h868;
  localparam logic [11:0] OFS_LINK_CTRL_F     = 12'h86c;
  localparam logic [11:0] OFS_TEST_FLAGS      = 12'h870;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_IRQ_LEVEL_SENSE = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_PENDING     = 32'h5555_5554;
  localparam logic [31:0] RST_IRQ_BLOCK       = 32'h0000_0000;
  localparam logic [31:0] RST_LINK_CTRL_A     = 32'h0400_1060;
  localparam logic [31:0] RST_LINK_CTRL_B     = 32'h0400_0800;
  localparam logic [7:0]  RST_FWD_POLICY      = 8'hc2;
  localparam logic [31:0] RST_LINK_CTRL_C     = 32'h76b5_0080;
  localparam logic [31:0] RST_PHY_MAIN        = 32'h0010_1d27;
  localparam logic [31:0] RST_PHY_LANE        = 32'h0000_8000;
  localparam logic [14:0] RST_PHY_MARGIN      = 15'h116b;
  localparam logic [31:0] RST_LINK_CTRL_D     = 32'h000f_0000;
  localparam logic [31:0] RST_LINK_CTRL_E     = 32'h0000_0000;
  localparam logic [31:0] RST_LINK_CTRL_F_DN  = 32'h3308_0008;
  localparam logic [31:0] RST_LINK_CTRL_F_UP  = 32'h7308_0008;
  localparam logic [2:0]  RST_TEST_RW         = 3'h0;

  // ----------------------------------------------------------------
  // Writable bit masks
  // ----------------------------------------------------------------
  localparam logic [31:0] WM_LINK_CTRL_C = 32'h7fff_7fff;
  localparam logic [31:0] WM_PHY_MAIN    = 32'h7fff_1f7f;
  localparam logic [31:0] WM_PHY_LANE    = 32'h0000_007f;
  localparam logic [31:0] WM_PHY_DELTA   = 32'hffff_8000;
  localparam logic [31:0] WM_PHY_MARGIN  = 32'h0000_7fff;
  localparam logic [31:0] WM_FWD_POLICY  = 32'h0000_007f;
  localparam logic [31:0] WM_TEST_RW     = 32'h0000_00e0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_STORE_FWD    = 0;
  localparam int POS_CT_ADV_LO    = 1;
  localparam int POS_ARB_HOLD     = 3;
  localparam int POS_CREDIT_ONE   = 4;
  localparam int POS_XPORT_ORDER  = 5;
  localparam int POS_TAG_ORDER    = 6;
  localparam int POS_NP_BUFFER    = 7;
  localparam int POS_CROSS_LINK   = 2;
  localparam int POS_ACK_TIMER    = 10;
  localparam int POS_DECODE_EN    = 31;
  localparam int POS_TX_AMPLITUDE = 30;
  localparam int POS_GEN1_LIMIT   = 31;
  localparam int POS_LANE_LO      = 0;
  localparam int POS_DELTA_LO     = 15;
  localparam int POS_TEST_RW_LO   = 5;
  localparam int POS_DMA_CAP      = 13;
  localparam int POS_STRAP        = 14;

  // Fixed read-only test bits of the capability word
  localparam logic [31:0] RO_TEST_FLAGS = 32'h0000_9014;

endpackage

// file: core/spcb_csr_bank.sv
`timescale 1ns/10ps

module spcb_csr_bank
  import spcb_pkg::*;
#(
  parameter bit          IS_UPSTREAM = 1'b1,
  parameter bit          DECODE_EN   = 1'b1,
  parameter bit          DMA_CAP     = 1'b1,
  parameter int unsigned GPIO_PINS   = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire logic [11:0]          cfg_addr,
  input  wire logic [3:0]           cfg_be,
  input  wire logic [31:0]          cfg_wdata,
  input  wire logic                 cfg_upstream,
  output logic      [31:0]          cfg_rdata,
  output logic                      cfg_rd_ack,
  input  wire logic [GPIO_PINS-1:0] gpio_irq_in,
  input  wire logic                 nontransparent_strap_pin,
  output logic                      gpio_irq_event,
  output logic                      store_forward_en,
  output logic      [1:0]           cut_through_advance,
  output logic                      arb_hold_grant,
  output logic                      credit_single_step,
  output logic                      cross_port_order_en,
  output logic                      completion_tag_order_en,
  output logic                      nonposted_buffering_select,
  output logic                      cross_link_en,
  output logic                      ack_latency_timer_en,
  output logic                      transmit_amplitude_select,
  output logic                      first_generation_limit,
  output logic      [6:0]           lane_mode,
  output logic      [16:0]          phy_delta
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] level_sense;
    logic [31:0] pending;
    logic [31:0] block;
    logic [31:0] link_a;
    logic [31:0] link_b;
    logic [7:0]  policy;
    logic [31:0] link_c;
    logic [31:0] phy_main;
    logic [31:0] phy_lane;
    logic [14:0] margin;
    logic [31:0] link_d;
    logic [31:0] link_e;
    logic [31:0] link_f;
    logic [2:0]  test_rw;
    logic        strap_done;
    logic        strap;
    logic        irq_event;
    logic [31:0] rdata;
    logic        rd_ack;
  } spcb_state_s;

  localparam logic [31:0] RST_LINK_CTRL_F =
    IS_UPSTREAM ? RST_LINK_CTRL_F_UP : RST_LINK_CTRL_F_DN;

  localparam spcb_state_s RST_STATE = '{
    level_sense: RST_IRQ_LEVEL_SENSE,
    pending:     RST_IRQ_PENDING,
    block:       RST_IRQ_BLOCK,
    link_a:      RST_LINK_CTRL_A,
    link_b:      RST_LINK_CTRL_B,
    policy:      RST_FWD_POLICY,
    link_c:      RST_LINK_CTRL_C,
    phy_main:    RST_PHY_MAIN,
    phy_lane:    RST_PHY_LANE,
    margin:      RST_PHY_MARGIN,
    link_d:      RST_LINK_CTRL_D,
    link_e:      RST_LINK_CTRL_E,
    link_f:      RST_LINK_CTRL_F,
    test_rw:     RST_TEST_RW,
    strap_done:  1'b0,
    strap:       1'b0,
    irq_event:   1'b0,
    rdata:       32'h0000_0000,
    rd_ack:      1'b0
  };

  spcb_state_s st_r;
  spcb_state_s st_nxt;

  logic [31:0] pins_w;
  logic [31:0] pend_calc;
  logic [31:0] phy_wmask;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into the writable bits only
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be,
                                         input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~(lane & wmask)) | (wd & lane & wmask);
  endfunction

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    return a[11:2] == ofs[11:2];
  endfunction

  // Pins widened to the 32-bit register view
  assign pins_w = 32'(gpio_irq_in);

  // Active when pin level matches the selected polarity
  assign pend_calc = ~(pins_w ^ st_r.level_sense);

  // Delta field only accepts upstream-port writes
  assign phy_wmask = cfg_upstream ? (WM_PHY_LANE | WM_PHY_DELTA)
                                  : WM_PHY_LANE;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Live interrupt status and combined event
    st_nxt.pending   = pend_calc;
    st_nxt.irq_event = |(st_r.pending & ~st_r.block);
    // Strap caught once, on the first edge after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.strap      = nontransparent_strap_pin;
    end
    // Register writes
    if (cfg_wr) begin
      if (hit(cfg_addr, OFS_IRQ_LEVEL_SENSE)) begin
        st_nxt.level_sense = wmerge(st_r.level_sense, cfg_wdata,
                                    cfg_be, 32'hffff_ffff);
      end
      if (hit(cfg_addr, OFS_IRQ_BLOCK)) begin
        st_nxt.block = wmerge(st_r.block, cfg_wdata, cfg_be,
                              32'hffff_ffff);
      end
      if (hit(cfg_addr, OFS_LINK_CTRL_A)) begin
        st_nxt.link_a = wmerge(st_r.link_a, cfg_wdata, cfg_be,
                               32'hffff_ffff);
      end
      if (hit(cfg_addr, OFS_LINK_CTRL_B)) begin
        st_nxt.link_b = wmerge(st_r.link_b, cfg_wdata, cfg_be,
                               32'hffff_ffff);
      end
      if (hit(cfg_addr, OFS_FWD_POLICY) && cfg_be[0]) begin
        st_nxt.policy[6:0] = cfg_wdata[6:0];
        st_nxt.policy[7]   = ~cfg_wdata[POS_NP_BUFFER];
      end
      if (hit(cfg_addr, OFS_LINK_CTRL_C)) begin
        st_nxt.link_c = wmerge(st_r.link_c, cfg_wdata, cfg_be,
                               WM_LINK_CTRL_C);
      end
      if (hit(cfg_addr, OFS_PHY_MAIN)) begin
        st_nxt.phy_main = wmerge(st_r.phy_main, cfg_wdata, cfg_be,
                                 WM_PHY_MAIN);
      end
      if (hit(cfg_addr, OFS_PHY_LANE)) begin
        st_nxt.phy_lane = wmerge(st_r.phy_lane, cfg_wdata, cfg_be,
                                 phy_wmask);
      end
      if (hit(cfg_addr, OFS_PHY_MARGIN)) begin
        st_nxt.margin = 15'(wmerge(32'(st_r.margin), cfg_wdata,
                                   cfg_be, WM_PHY_MARGIN));
      end
      if (hit(cfg_addr, OFS_LINK_CTRL_D)) begin
        st_nxt.link_d = wmerge(st_r.link_d, cfg_wdata, cfg_be,
                               32'hffff_ffff);
      end
      if (hit(cfg_addr, OFS_LINK_CTRL_E)) begin
        st_nxt.link_e = wmerge(st_r.link_e, cfg_wdata, cfg_be,
                               32'hffff_ffff);
      end
      if (hit(cfg_addr, OFS_LINK_CTRL_F)) begin
        st_nxt.link_f = wmerge(st_r.link_f, cfg_wdata, cfg_be,
                               32'hffff_ffff);
      end
      if (hit(cfg_addr, OFS_TEST_FLAGS) && cfg_be[0]) begin
        st_nxt.test_rw = cfg_wdata[7:5];
      end
    end
    // Read data, answered on the next edge; unmapped reads zero
    st_nxt.rd_ack = cfg_rd;
    st_nxt.rdata  = 32'h0000_0000;
    if (cfg_rd) begin
      unique case (cfg_addr[11:2])
        OFS_IRQ_LEVEL_SENSE[11:2]: st_nxt.rdata = st_r.level_sense;
        OFS_IRQ_PENDING[11:2]:     st_nxt.rdata = st_r.pending;
        OFS_IRQ_BLOCK[11:2]:       st_nxt.rdata = st_r.block;
        OFS_LINK_CTRL_A[11:2]:     st_nxt.rdata = st_r.link_a;
        OFS_LINK_CTRL_B[11:2]:     st_nxt.rdata = st_r.link_b;
        OFS_LEGACY_DECODE[11:2]:
          st_nxt.rdata = 32'(DECODE_EN) << POS_DECODE_EN;
        OFS_FWD_POLICY[11:2]:      st_nxt.rdata = 32'(st_r.policy);
        OFS_LINK_CTRL_C[11:2]:     st_nxt.rdata = st_r.link_c;
        OFS_PHY_MAIN[11:2]:        st_nxt.rdata = st_r.phy_main;
        OFS_PHY_LANE[11:2]:        st_nxt.rdata = st_r.phy_lane;
        OFS_PHY_MARGIN[11:2]:      st_nxt.rdata = 32'(st_r.margin);
        OFS_LINK_CTRL_D[11:2]:     st_nxt.rdata = st_r.link_d;
        OFS_LINK_CTRL_E[11:2]:     st_nxt.rdata = st_r.link_e;
        OFS_LINK_CTRL_F[11:2]:     st_nxt.rdata = st_r.link_f;
        OFS_TEST_FLAGS[11:2]: begin
          st_nxt.rdata = (RO_TEST_FLAGS & ~(32'h1 << POS_DMA_CAP))
                       | (32'(DMA_CAP) << POS_DMA_CAP)
                       | (32'(st_r.strap) << POS_STRAP)
                       | (32'(st_r.test_rw) << POS_TEST_RW_LO);
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus answer and interrupt event
  assign cfg_rdata      = st_r.rdata;
  assign cfg_rd_ack     = st_r.rd_ack;
  assign gpio_irq_event = st_r.irq_event;

  // Forwarding and arbitration controls
  assign store_forward_en        = st_r.policy[POS_STORE_FWD];
  assign cut_through_advance     = st_r.policy[POS_CT_ADV_LO+:2];
  assign arb_hold_grant          = st_r.policy[POS_ARB_HOLD];
  assign credit_single_step      = st_r.policy[POS_CREDIT_ONE];
  assign cross_port_order_en     = st_r.policy[POS_XPORT_ORDER];
  assign completion_tag_order_en = st_r.policy[POS_TAG_ORDER];
  assign nonposted_buffering_select = st_r.policy[POS_NP_BUFFER];

  // Link and physical-layer controls
  assign cross_link_en             = st_r.link_a[POS_CROSS_LINK];
  assign ack_latency_timer_en      = st_r.link_f[POS_ACK_TIMER];
  assign transmit_amplitude_select = st_r.phy_main[POS_TX_AMPLITUDE];
  assign first_generation_limit    = st_r.link_f[POS_GEN1_LIMIT];
  assign lane_mode = st_r.phy_lane[POS_LANE_LO+:7];
  assign phy_delta = st_r.phy_lane[POS_DELTA_LO+:17];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pending_track: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> st_r.pending == $past(pend_calc))
    else $error("status word does not follow pins and polarity");

  a_status_ro: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_IRQ_PENDING)) |=>
      st_r.pending == $past(pend_calc))
    else $error("status word changed by a write");

  a_mask_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_IRQ_BLOCK) && cfg_be == 4'hf) |=>
      st_r.block == $past(cfg_wdata))
    else $error("mask write not stored");

  a_irq_event: assert property (
    @(posedge clk) disable iff (!rst_n)
    (|(st_r.pending & ~st_r.block)) |=> gpio_irq_event)
    else $error("unmasked active pin gave no event");

  a_irq_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(|(st_r.pending & ~st_r.block)) |=> !gpio_irq_event)
    else $error("event without unmasked active pin");

  a_fwd_mode: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_FWD_POLICY) && cfg_be[0]) |=>
      store_forward_en == $past(cfg_wdata[0]) &&
      cut_through_advance == $past(cfg_wdata[2:1]))
    else $error("forwarding mode not taken from write");

  a_np_invert: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_FWD_POLICY) && cfg_be[0]) |=>
      nonposted_buffering_select != $past(cfg_wdata[7]))
    else $error("non-posted select not inverted on write");

  a_cross_link: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_LINK_CTRL_A) && cfg_be[0]) |=>
      cross_link_en == $past(cfg_wdata[2]))
    else $error("crossed-link enable not written");

  a_decode_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit(cfg_addr, OFS_LEGACY_DECODE)) |=>
      cfg_rd_ack && cfg_rdata[POS_DECODE_EN] == DECODE_EN)
    else $error("legacy decode bit read wrong");

  a_delta_guard: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_PHY_LANE) && !cfg_upstream) |=>
      $stable(phy_delta))
    else $error("delta changed by downstream write");

  a_dma_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_rd && hit(cfg_addr, OFS_TEST_FLAGS)) |=>
      cfg_rd_ack && cfg_rdata[POS_DMA_CAP] == DMA_CAP)
    else $error("DMA capability bit read wrong");

  a_strap_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_r.strap_done |=> $stable(st_r.strap))
    else $error("strap bit changed after capture");

  a_strap_capture: assert property (
    @(posedge clk) disable iff (!rst_n)
    !st_r.strap_done |=> st_r.strap == $past(nontransparent_strap_pin))
    else $error("strap bit not taken from pin");

  a_mask_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> st_r.block == 32'h0000_0000)
    else $error("mask not clear after reset");

  a_policy_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_FWD_POLICY) && cfg_be[0]) |=>
      arb_hold_grant == $past(cfg_wdata[3]) &&
      credit_single_step == $past(cfg_wdata[4]))
    else $error("arbitration or credit mode not taken from write");

  a_order_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_FWD_POLICY) && cfg_be[0]) |=>
      cross_port_order_en == $past(cfg_wdata[5]) &&
      completion_tag_order_en == $past(cfg_wdata[6]))
    else $error("ordering modes not taken from write");

  a_swing_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_PHY_MAIN) && cfg_be[3]) |=>
      transmit_amplitude_select == $past(cfg_wdata[30]))
    else $error("swing select not taken from write");

  a_gen_limit: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_LINK_CTRL_F) && cfg_be[3]) |=>
      first_generation_limit == $past(cfg_wdata[31]))
    else $error("generation limit not taken from write");

  a_ack_timer: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg_wr && hit(cfg_addr, OFS_LINK_CTRL_F) && cfg_be[1]) |=>
      ack_latency_timer_en == $past(cfg_wdata[10]))
    else $error("ack timer enable not taken from write");

endmodule

// file: testbench/test_switch_port_config_csr_bank.sv
`timescale 1ns/10ps
module test_switch_port_config_csr_bank
  import spcb_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic        cfg_upstream;
  logic [31:0] cfg_rdata;
  logic        cfg_rd_ack;
  logic [31:0] gpio_in;
  logic        strap;
  logic        irq_ev;
  logic [7:0]  pol_outs;
  logic [27:0] misc_outs;
  logic [6:0]  lane;
  logic [16:0] delta;
  int          n_errors;
  int          checks_done;
  int          i;
  logic [7:0]  v;
  logic [11:0] ra [16] = '{12'h64c, 12'h650, 12'h654, 12'h844, 12'h848,
    12'h84c, 12'h850, 12'h854, 12'h858, 12'h85c, 12'h860, 12'h864, 12'h868,
    12'h86c, 12'h870, 12'h700};
  logic [31:0] rv [16] = '{32'h0, 32'h5555_5554, 32'h0, 32'h0400_1060,
    32'h0400_0800, 32'h8000_0000, 32'h0000_00c2, 32'h76b5_0080,
    32'h0010_1d27, 32'h0000_8000, 32'h0000_116b, 32'h000f_0000, 32'h0,
    32'h7308_0008, 32'h0000_f014, 32'h0};
  logic [7:0]  pv [4] = '{8'h00, 8'hff, 8'h55, 8'haa};

  // ---------------------------------------------------------------
  // Device under test
  // ---------------------------------------------------------------
  spcb_csr_bank i_spcb_csr_bank (
    .clk                        (clk),
    .rst_n                      (rst_n),
    .cfg_wr                     (cfg_wr),
    .cfg_rd                     (cfg_rd),
    .cfg_addr                   (cfg_addr),
    .cfg_be                     (cfg_be),
    .cfg_wdata                  (cfg_wdata),
    .cfg_upstream               (cfg_upstream),
    .cfg_rdata                  (cfg_rdata),
    .cfg_rd_ack                 (cfg_rd_ack),
    .gpio_irq_in                (gpio_in),
    .nontransparent_strap_pin   (strap),
    .gpio_irq_event             (irq_ev),
    .store_forward_en           (pol_outs[0]),
    .cut_through_advance        (pol_outs[2:1]),
    .arb_hold_grant             (pol_outs[3]),
    .credit_single_step         (pol_outs[4]),
    .cross_port_order_en        (pol_outs[5]),
    .completion_tag_order_en    (pol_outs[6]),
    .nonposted_buffering_select (pol_outs[7]),
    .cross_link_en              (misc_outs[27]),
    .ack_latency_timer_en       (misc_outs[26]),
    .transmit_amplitude_select  (misc_outs[25]),
    .first_generation_limit     (misc_outs[24]),
    .lane_mode                  (lane),
    .phy_delta                  (delta)
  );
  assign misc_outs[23:0] = {lane, delta};

  // Clock generator
  always #12.5 clk = ~clk;

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // One write pulse
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    @(posedge clk);
    #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
  endtask

  // One read pulse, bounded wait for the answer
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    int k;
    @(posedge clk);
    #1;
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1;
    cfg_rd = 1'b0;
    k = 0;
    while (cfg_rd_ack !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 4) begin
      n_errors++;
      $display("[ERR] read ack %h exp 1 got 0", a);
      summarize();
    end else begin
      chk($sformatf("reg %h", a), e, cfg_rdata);
    end
  endtask

  // Let the interrupt path settle
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 12'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    cfg_upstream = 1'b1;
    gpio_in = 32'haaaa_aaab;
    strap = 1'b1;
    n_errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (i = 0; i < 16; i++) rd(ra[i], rv[i]);
    chk("policy outs", 32'hc2, {24'h0, pol_outs});
    chk("phy outs", 32'h1, {4'h0, misc_outs});
    chk("irq event", 32'h1, {31'h0, irq_ev});
    // Four policy codes (00, ff, 55, aa), inverse store on bit 7
    for (i = 0; i < 4; i++) begin
      v = pv[i];
      wr(12'h850, {24'h0, v}, 4'h1);
      chk("policy outs", {24'h0, ~v[7], v[6:0]}, {24'h0, pol_outs});
      rd(12'h850, {24'h0, ~v[7], v[6:0]});
    end
    wr(12'h850, 32'h0, 4'he);
    rd(12'h850, 32'h0000_002a);
    // Link and phy fields, delta gated by port
    wr(12'h844, 32'h4, 4'hf);
    wr(12'h858, 32'h4000_0000, 4'hf);
    wr(12'h86c, 32'h8000_0400, 4'hf);
    cfg_upstream = 1'b0;
    wr(12'h85c, 32'hffff_ffff, 4'hf);
    chk("phy outs", 32'h0ffe_0001, {4'h0, misc_outs});
    rd(12'h844, 32'h4);
    rd(12'h858, 32'h4000_0000);
    rd(12'h86c, 32'h8000_0400);
    rd(12'h85c, 32'h0000_807f);
    cfg_upstream = 1'b1;
    wr(12'h85c, 32'hffff_ffff, 4'hf);
    rd(12'h85c, 32'hffff_807f);
    chk("phy delta", 32'h1_ffff, {15'h0, delta});
    // Read-only places, byte lanes, unmapped
    wr(12'h84c, 32'h0, 4'hf);
    wr(12'h650, 32'h0, 4'hf);
    wr(12'h870, 32'hffff_ffff, 4'hf);
    wr(12'h864, 32'hffff_ffff, 4'h2);
    wr(12'h700, 32'hffff_ffff, 4'hf);
    rd(12'h84c, 32'h8000_0000);
    rd(12'h650, 32'h5555_5554);
    rd(12'h870, 32'h0000_f0f4);
    rd(12'h864, 32'h000f_ff00);
    rd(12'h700, 32'h0);
    // Polarity flip, masking, combined event
    wr(12'h64c, 32'hffff_ffff, 4'hf);
    rd(12'h650, 32'haaaa_aaab);
    wr(12'h654, 32'hffff_fffe, 4'hf);
    settle();
    chk("irq event", 32'h1, {31'h0, irq_ev});
    gpio_in = 32'haaaa_aaaa;
    settle();
    chk("irq event", 32'h0, {31'h0, irq_ev});
    rd(12'h650, 32'haaaa_aaaa);
    wr(12'h654, 32'h0, 4'hf);
    settle();
    chk("irq event", 32'h1, {31'h0, irq_ev});
    summarize();
  end
endmodule
